// ### verilog/mwr_pkg.sv
// Package of constants and types for the multi-window readout scanner
// Notes on behaviour
// - One kernel of 64 adjacent pixels is read per clock; columns step in kernels.
// - Column begin is in kernels; first pixel column is begin times 64.
// - Column bounds are 7-bit fields, row bounds 13-bit fields.
// - Up to 32 windows are held; they may overlap fully or partly.
// - Pixel (0,0) is the bottom-left corner; lines count upward from it.
// - Decimation forces even begins; ends even for subsampling, odd for binning.
// - Multiple windows are scanned only in global shutter mode.
// - Line pointer loads first row begin, steps per line, stops after last row end.
// - Each line scans only windows covering it, starting at lowest-ID window begin.
// - At a window end the kernel jumps to the next begin, else the line ends.
// - Line pointer jumps to the next row begin over lines no window covers.
// - Rolling shutter reads one selected window; selection may change while running.
// - Rolling shutter mutes frames corrupted by a window change while running.
// - Subsampling and 2x2 binning cut samples by four, 2x1 binning by two, over the same optical area.
// - With binning, the 2D bit picks 2x2 averaging, clear picks 2x1 in x.
// - The color variant offers no binning.
// - Subsampling reads one skip one on monochrome, two skip two on color.
package mwr_pkg;
    localparam int KERNEL_PIXELS = 64;
    localparam int NUM_WIN = 32;
    localparam int ID_W = 5;
    localparam int COL_W = 7;
    localparam int ROW_W = 13;
    localparam int WORD_W = ID_W + ROW_W + COL_W;
    localparam int FIFO_DEPTH = 4;
    // Field positions inside an output word
    localparam int WORD_COL_LSB = 0;
    localparam int WORD_ROW_LSB = COL_W;
    localparam int WORD_ID_LSB = COL_W + ROW_W;
    // Reset values of the window store
    localparam logic [COL_W-1:0] COL_RESET = 7'h00;
    localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
    // Legal ranges kept by software
    localparam logic [COL_W-1:0] COL_MIN = 7'h06;
    localparam logic [COL_W-1:0] COL_MAX = 7'h49;
    localparam logic [ROW_W-1:0] ROW_MIN_LARGE = 13'h01FC;
    localparam logic [ROW_W-1:0] ROW_MAX_LARGE = 13'h1203;
    localparam logic [ROW_W-1:0] ROW_MIN_SMALL = 13'h03FC;
    localparam logic [ROW_W-1:0] ROW_MAX_SMALL = 13'h1003;
    // Line steps for the decimation orderings
    localparam logic [ROW_W:0] STEP_ONE = 14'h0001;
    localparam logic [ROW_W:0] STEP_TWO = 14'h0002;
    localparam logic [ROW_W:0] STEP_THREE = 14'h0003;
    typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_SCAN} mwr_state_t;
endpackage : mwr_pkg

// ### verilog/mwr_word_if.sv
// Interface carrying scan words between scanner and FIFO
`timescale 1ns/1ps
interface mwr_word_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : mwr_word_if

// ### verilog/mwr_sync2.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module mwr_sync2 (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            level_out <= meta_reg;
        end
    end
endmodule : mwr_sync2

// ### verilog/mwr_fifo.sv
// Flop-based FIFO for scan words
`timescale 1ns/1ps
module mwr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    mwr_word_if.snk wr,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic do_wr;
    logic do_rd;
    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rp_reg];
    assign do_wr = wr.valid && wr.ready;
    assign do_rd = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem_reg[wp_reg] <= wr.data;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_wr) begin
                wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
            end
            if (do_rd) begin
                rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule : mwr_fifo

// ### verilog/mwr_scanner.sv
// Multi-window readout scanner: window store, line and kernel walk, output FIFO
`timescale 1ns/1ps
module mwr_scanner
    import mwr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic frame_trigger,
    input wire logic cfg_write,
    input wire logic [mwr_pkg::ID_W-1:0] cfg_index,
    input wire logic [mwr_pkg::COL_W-1:0] cfg_column_begin,
    input wire logic [mwr_pkg::COL_W-1:0] cfg_column_end,
    input wire logic [mwr_pkg::ROW_W-1:0] cfg_row_begin,
    input wire logic [mwr_pkg::ROW_W-1:0] cfg_row_end,
    input wire logic cfg_active,
    input wire logic rolling_shutter,
    input wire logic [mwr_pkg::ID_W-1:0] rolling_window_select,
    input wire logic subsample_enable,
    input wire logic binning_enable,
    input wire logic binning_2d,
    input wire logic color_variant,
    output logic word_valid,
    input wire logic word_ready,
    output logic [mwr_pkg::WORD_W-1:0] word_data,
    output logic frame_busy_reg,
    output logic frame_done_reg,
    output logic frame_blank_reg
);
    import mwr_pkg::*;

    // ********************************
    // Window store
    // ********************************
    logic [COL_W-1:0] cb_reg [NUM_WIN];
    logic [COL_W-1:0] ce_reg [NUM_WIN];
    logic [ROW_W-1:0] rb_reg [NUM_WIN];
    logic [ROW_W-1:0] re_reg [NUM_WIN];
    logic [NUM_WIN-1:0] act_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_WIN; i++) begin
                cb_reg[i] <= COL_RESET;
                ce_reg[i] <= COL_RESET;
                rb_reg[i] <= ROW_RESET;
                re_reg[i] <= ROW_RESET;
            end
            act_reg <= '0;
        end else if (cfg_write) begin
            cb_reg[cfg_index] <= cfg_column_begin;
            ce_reg[cfg_index] <= cfg_column_end;
            rb_reg[cfg_index] <= cfg_row_begin;
            re_reg[cfg_index] <= cfg_row_end;
            act_reg[cfg_index] <= cfg_active;
        end
    end

    // ********************************
    // Frame trigger
    // ********************************
    logic trig_sync;
    logic trig_prev_reg;
    logic frame_start;
    mwr_sync2 u_trig_sync (
        .clock(clock),
        .rst(rst),
        .pin_in(frame_trigger),
        .level_out(trig_sync)
    );
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_sync;
        end
    end
    assign frame_start = trig_sync && !trig_prev_reg;

    // ********************************
    // Decimation
    // ********************************
    logic bin_eff;
    logic decim;
    assign bin_eff = binning_enable && !color_variant;
    assign decim = subsample_enable || bin_eff;

    function automatic logic [COL_W-1:0] fix_begin(input logic [COL_W-1:0] b);
        fix_begin = decim ? {b[COL_W-1:1], 1'b0} : b;
    endfunction : fix_begin

    function automatic logic [COL_W-1:0] fix_end(input logic [COL_W-1:0] e);
        if (subsample_enable) begin
            fix_end = {e[COL_W-1:1], 1'b0};
        end else if (bin_eff) begin
            fix_end = {e[COL_W-1:1], 1'b1};
        end else begin
            fix_end = e;
        end
    endfunction : fix_end

    // Lowest set index; windows are ID ordered left to right
    function automatic logic [ID_W:0] first_idx(input logic [NUM_WIN-1:0] m);
        first_idx = '0;
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_idx = {1'b1, ID_W'(i)};
            end
        end
    endfunction : first_idx

    // Smallest row begin among a set of windows
    function automatic logic [ROW_W:0] min_row(input logic [NUM_WIN-1:0] m);
        min_row = '0;
        for (int i = 0; i < NUM_WIN; i++) begin
            if (m[i] && (!min_row[ROW_W] || rb_reg[i] < min_row[ROW_W-1:0])) begin
                min_row = {1'b1, rb_reg[i]};
            end
        end
    endfunction : min_row

    // ********************************
    // Window masks
    // ********************************
    mwr_state_t state_reg;
    logic [ROW_W-1:0] line_pointer_reg;
    logic [COL_W-1:0] kernel_pointer_reg;
    logic [ID_W-1:0] win_id_reg;
    logic [ROW_W:0] step;
    logic [ROW_W:0] next_line_wide;
    logic [ROW_W-1:0] next_line;
    logic [NUM_WIN-1:0] en_mask;
    logic [NUM_WIN-1:0] cur_mask;
    logic [NUM_WIN-1:0] nxt_mask;
    logic [NUM_WIN-1:0] jump_mask;
    logic [NUM_WIN-1:0] started_mask;
    logic [NUM_WIN-1:0] later_mask;

    always_comb begin
        if (subsample_enable && color_variant) begin
            step = line_pointer_reg[0] ? STEP_THREE : STEP_ONE;
        end else if (subsample_enable || (bin_eff && binning_2d)) begin
            step = STEP_TWO;
        end else begin
            step = STEP_ONE;
        end
    end
    assign next_line_wide = {1'b0, line_pointer_reg} + step;
    assign next_line = next_line_wide[ROW_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_WIN; gi++) begin : g_mask
            // Rolling shutter keeps only the selected window
            assign en_mask[gi] = act_reg[gi] &&
                (!rolling_shutter || rolling_window_select == ID_W'(gi));
            // Lines count up from the bottom row
            assign cur_mask[gi] = en_mask[gi] && rb_reg[gi] <= line_pointer_reg
                && line_pointer_reg <= re_reg[gi];
            assign nxt_mask[gi] = en_mask[gi] && !next_line_wide[ROW_W]
                && rb_reg[gi] <= next_line && next_line <= re_reg[gi];
            assign jump_mask[gi] = en_mask[gi] && rb_reg[gi] > line_pointer_reg;
            assign started_mask[gi] = cur_mask[gi]
                && fix_begin(cb_reg[gi]) <= kernel_pointer_reg;
            assign later_mask[gi] = cur_mask[gi]
                && fix_begin(cb_reg[gi]) > kernel_pointer_reg;
        end
    endgenerate

    // ********************************
    // Scan decisions
    // ********************************
    logic [ROW_W:0] first_row;
    logic [ROW_W:0] jump_row;
    logic [ID_W:0] line_first;
    logic [ID_W:0] next_win;
    logic [ID_W-1:0] cur_win;
    logic [COL_W-1:0] cur_end;
    logic in_window;
    logic push_ok;
    logic advance;
    logic line_end;
    // Function bodies read the window store, so always_comb keeps them fresh
    always_comb begin
        first_row = min_row(en_mask);
        jump_row = min_row(jump_mask);
    end
    assign line_first = first_idx(cur_mask);
    assign next_win = first_idx(later_mask);

    // Highest started window carries the furthest end
    always_comb begin
        cur_win = '0;
        for (int i = 0; i < NUM_WIN; i++) begin
            if (started_mask[i]) begin
                cur_win = ID_W'(i);
            end
        end
    end
    // Mode bits are read inside the function, hence always_comb
    always_comb begin
        cur_end = fix_end(ce_reg[cur_win]);
    end
    assign in_window = kernel_pointer_reg < cur_end;
    assign line_end = !in_window && !next_win[ID_W];

    // ********************************
    // Rolling change guard
    // ********************************
    logic [ID_W-1:0] sel_prev_reg;
    logic dyn_change;
    logic corrupt_reg;
    assign dyn_change = rolling_shutter && ((cfg_write && cfg_index == rolling_window_select)
        || sel_prev_reg != rolling_window_select);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_prev_reg <= '0;
            corrupt_reg <= 1'b0;
            frame_blank_reg <= 1'b0;
        end else begin
            sel_prev_reg <= rolling_window_select;
            // Transients also spoil the frame after, so it is muted too
            if (dyn_change) begin
                corrupt_reg <= 1'b1;
                frame_blank_reg <= 1'b1;
            end else if (frame_start && state_reg == ST_IDLE) begin
                corrupt_reg <= 1'b0;
                frame_blank_reg <= corrupt_reg;
            end
        end
    end

    // ********************************
    // Output path
    // ********************************
    mwr_word_if #(.W(WORD_W)) push_if ();
    assign push_if.valid = (state_reg == ST_SCAN) && !frame_blank_reg;
    assign push_if.data = {win_id_reg, line_pointer_reg, kernel_pointer_reg};
    // A full FIFO stalls the walk; muted frames run at full speed
    assign push_ok = push_if.ready || frame_blank_reg;
    assign advance = (state_reg == ST_SCAN) && push_ok;

    mwr_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .wr(push_if),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // ********************************
    // Sequencer
    // ********************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            line_pointer_reg <= ROW_RESET;
            kernel_pointer_reg <= COL_RESET;
            win_id_reg <= '0;
            frame_busy_reg <= 1'b0;
            frame_done_reg <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (frame_start && first_row[ROW_W]) begin
                        line_pointer_reg <= first_row[ROW_W-1:0];
                        state_reg <= ST_LINE;
                        frame_busy_reg <= 1'b1;
                    end
                end
                ST_LINE: begin
                    if (line_first[ID_W]) begin
                        kernel_pointer_reg <= fix_begin(cb_reg[line_first[ID_W-1:0]]);
                        win_id_reg <= line_first[ID_W-1:0];
                        state_reg <= ST_SCAN;
                    end else begin
                        state_reg <= ST_IDLE;
                        frame_busy_reg <= 1'b0;
                        frame_done_reg <= 1'b1;
                    end
                end
                ST_SCAN: begin
                    if (advance) begin
                        if (in_window) begin
                            kernel_pointer_reg <= kernel_pointer_reg + 1'b1;
                            win_id_reg <= cur_win;
                        end else if (next_win[ID_W]) begin
                            kernel_pointer_reg <= fix_begin(cb_reg[next_win[ID_W-1:0]]);
                            win_id_reg <= next_win[ID_W-1:0];
                        end else if (|nxt_mask) begin
                            line_pointer_reg <= next_line;
                            state_reg <= ST_LINE;
                        end else if (jump_row[ROW_W]) begin
                            line_pointer_reg <= jump_row[ROW_W-1:0];
                            state_reg <= ST_LINE;
                        end else begin
                            state_reg <= ST_IDLE;
                            frame_busy_reg <= 1'b0;
                            frame_done_reg <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb_chk @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence seq_frame_go;
        state_reg == ST_IDLE && frame_start && first_row[ROW_W];
    endsequence
    sequence seq_line_open;
        state_reg == ST_LINE && line_first[ID_W];
    endsequence

    a_frame_first_line: assert property (seq_frame_go |=>
        line_pointer_reg == $past(first_row[ROW_W-1:0]) && state_reg == ST_LINE)
        else $error("line pointer did not load first row begin");
    a_line_first_kernel: assert property (seq_line_open |=>
        state_reg == ST_SCAN && win_id_reg == $past(line_first[ID_W-1:0])
        && (!decim || !kernel_pointer_reg[0]))
        else $error("line did not start at lowest window begin");
    a_kernel_step_one: assert property (advance && in_window |=>
        kernel_pointer_reg == $past(kernel_pointer_reg) + 7'h01)
        else $error("kernel pointer did not step by one kernel");
    a_kernel_jump_win: assert property (advance && !in_window && next_win[ID_W] |=>
        state_reg == ST_SCAN && win_id_reg == $past(next_win[ID_W-1:0]))
        else $error("kernel pointer missed jump to next window");
    a_line_skip_gap: assert property (advance && line_end && !(|nxt_mask)
        && jump_row[ROW_W] |=> line_pointer_reg == $past(jump_row[ROW_W-1:0])
        ##1 state_reg == ST_SCAN)
        else $error("line pointer did not jump over empty lines");
    a_mono_sub_step: assert property (advance && line_end && |nxt_mask
        && subsample_enable && !color_variant
        |=> line_pointer_reg == $past(line_pointer_reg) + 13'h0002)
        else $error("monochrome subsampling did not skip one line");
    a_rolling_one_win: assert property (rolling_shutter && state_reg == ST_SCAN |->
        win_id_reg == rolling_window_select || frame_blank_reg || dyn_change)
        else $error("rolling shutter scanned a second window");
    a_blank_mutes_push: assert property (dyn_change |=>
        frame_blank_reg && !push_if.valid)
        else $error("corrupted rolling frame was not muted");
    a_color_no_bin: assert property (color_variant && binning_enable
        && !subsample_enable |-> !decim && step == STEP_ONE)
        else $error("binning applied on color variant");
endmodule : mwr_scanner

// ### dv/mwr_sink_model.sv
// Sink model standing for the controller that takes scan words
`timescale 1ns/1ps
module mwr_sink_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    output logic word_ready
);
    // ****************
    // Ready pattern
    // ****************
    logic [2:0] tick_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_reg <= 3'h0;
            word_ready <= 1'b0;
        end else begin
            tick_reg <= tick_reg + 3'h1;
            // One word in eight when slow, so the FIFO fills and scanning stalls
            word_ready <= !slow || (tick_reg == 3'h7);
        end
    end
endmodule : mwr_sink_model

// ### dv/mwr_scanner_tb_top.sv
// Self-checking bench for the multi-window readout scanner
`timescale 1ns/1ps
module mwr_scanner_tb_top;
    import mwr_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic frame_trigger = 1'b0;
    logic cfg_write = 1'b0;
    logic [ID_W-1:0] cfg_index = '0;
    logic [COL_W-1:0] cfg_column_begin = '0, cfg_column_end = '0;
    logic [ROW_W-1:0] cfg_row_begin = '0, cfg_row_end = '0;
    logic cfg_active = 1'b0;
    logic rolling_shutter = 1'b0;
    logic [ID_W-1:0] rolling_window_select = '0;
    logic subsample_enable = 1'b0, binning_enable = 1'b0;
    logic binning_2d = 1'b0, color_variant = 1'b0;
    logic word_valid, word_ready, frame_busy_reg, frame_done_reg, frame_blank_reg;
    logic [WORD_W-1:0] word_data;
    logic slow = 1'b0;
    logic seen_busy = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'd18;
    logic [WORD_W:0] exp_q[$];
    logic [WORD_W:0] note;
    logic [COL_W-1:0] wb[NUM_WIN], we[NUM_WIN];
    logic [ROW_W-1:0] rb[NUM_WIN], re[NUM_WIN];
    logic act[NUM_WIN];
    localparam int RB = 32'h00000200;

    always #12.5 clock = ~clock;

    mwr_scanner DUT (.clock(clock), .rst(rst), .frame_trigger(frame_trigger),
        .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_column_begin(cfg_column_begin),
        .cfg_column_end(cfg_column_end), .cfg_row_begin(cfg_row_begin),
        .cfg_row_end(cfg_row_end), .cfg_active(cfg_active), .rolling_shutter(rolling_shutter),
        .rolling_window_select(rolling_window_select), .subsample_enable(subsample_enable),
        .binning_enable(binning_enable), .binning_2d(binning_2d),
        .color_variant(color_variant), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .frame_busy_reg(frame_busy_reg),
        .frame_done_reg(frame_done_reg), .frame_blank_reg(frame_blank_reg));

    mwr_sink_model SINK (.clock(clock), .rst(rst), .slow(slow), .word_ready(word_ready));

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    function automatic logic enab(input int w);
        return act[w] && (!rolling_shutter || w == rolling_window_select);
    endfunction : enab

    function automatic logic covered(input int ln);
        for (int w = 0; w < NUM_WIN; w++) begin
            if (enab(w) && ln >= rb[w] && ln <= re[w]) return 1'b1;
        end
        return 1'b0;
    endfunction : covered

    // Reference walk: ascending kernels over the union of windows on each line
    task automatic expect_frame();
        int ln, nx, n, id;
        logic [COL_W-1:0] b, e;
        logic bin;
        bin = binning_enable && !color_variant;
        ln = 8192;
        for (int w = 0; w < NUM_WIN; w++) if (enab(w) && rb[w] < ln) ln = rb[w];
        while (ln < 8192) begin
            for (int k = 0; k < 128; k++) begin
                n = 0;
                for (int w = 0; w < NUM_WIN; w++) begin
                    b = wb[w];
                    e = we[w];
                    if (subsample_enable || bin) b[0] = 1'b0;
                    if (subsample_enable) e[0] = 1'b0;
                    else if (bin) e[0] = 1'b1;
                    if (enab(w) && ln >= rb[w] && ln <= re[w] && k >= b && k <= e) begin
                        n++;
                        id = w;
                    end
                end
                if (n > 0) exp_q.push_back({n == 1, id[4:0], ln[12:0], k[6:0]});
            end
            if (subsample_enable && color_variant) nx = ln + (ln[0] ? 3 : 1);
            else nx = ln + ((subsample_enable || (bin && binning_2d)) ? 2 : 1);
            if (!covered(nx)) begin
                nx = 8192;
                for (int w = 0; w < NUM_WIN; w++) begin
                    if (enab(w) && rb[w] > ln && rb[w] < nx) nx = rb[w];
                end
            end
            ln = nx;
        end
    endtask : expect_frame

    task automatic cfg(input int w, input int b, input int e, input int r0, input int r1,
                       input logic a);
        @(posedge clock);
        cfg_write <= 1'b1;
        cfg_index <= w[4:0];
        cfg_column_begin <= b[6:0];
        cfg_column_end <= e[6:0];
        cfg_row_begin <= r0[12:0];
        cfg_row_end <= r1[12:0];
        cfg_active <= a;
        {wb[w], we[w], rb[w], re[w], act[w]} = {b[6:0], e[6:0], r0[12:0], r1[12:0], a};
        @(posedge clock);
        cfg_write <= 1'b0;
    endtask : cfg

    task automatic mode(input logic [4:0] m, input int sel);
        @(posedge clock);
        {color_variant, binning_2d, binning_enable, subsample_enable, rolling_shutter} <= m;
        rolling_window_select <= sel[4:0];
        seed = xorshift(seed);
        slow <= seed[0];
    endtask : mode

    task automatic run_frame(input string name, input logic mute);
        int t;
        @(posedge clock);
        expect_frame();
        if (mute) exp_q.delete();
        seen_busy = 1'b0;
        frame_trigger <= 1'b1;
        repeat (4) @(posedge clock);
        frame_trigger <= 1'b0;
        t = 0;
        while (frame_done_reg !== 1'b1 && t < 20000) begin
            @(negedge clock);
            t++;
        end
        check("frame done", 1, t < 20000);
        check("frame busy", 1, seen_busy);
        while (exp_q.size() > 0 && t < 20000) begin
            @(negedge clock);
            t++;
        end
        repeat (20) @(negedge clock);
        check("words left", 0, exp_q.size());
        $display("Test %s finished", name);
    endtask : run_frame

    // ****************
    // Watchers
    // ****************
    always @(negedge clock) if (frame_busy_reg === 1'b1) seen_busy = 1'b1;

    // Sampled mid-cycle, where the handshake has settled
    always @(negedge clock) begin
        if (!rst && word_valid === 1'b1 && word_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_checks++;
                fail_count++;
                $display("MISMATCH extra word expected none seen %0h", word_data);
            end else begin
                note = exp_q.pop_front();
                check("line and kernel", note[19:0], word_data[19:0]);
                if (note[WORD_W]) check("window id", note[24:20], word_data[24:20]);
            end
        end
    end

    initial begin
        #(25ns * 60000);
        fail_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        results();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        cfg(0, 7, 10, RB, RB + 7, 1'b1);
        exp_q.delete();
        for (int i = 0; i < 6; i++) begin
            mode(i == 0 ? 5'h02 : i == 1 ? 5'h0C : i == 2 ? 5'h04 : i == 3 ? 5'h12 :
                 i == 4 ? 5'h1C : 5'h00, 0);
            run_frame("decimation", 1'b0);
        end
        seed = xorshift(seed);
        // Begin below end, row end above row begin, ID order left to right per line
        cfg(0, 6, 7, RB + 10, RB + 11, 1'b1);
        cfg(1, 10, 11, RB + 11, RB + 12, 1'b1);
        cfg(5, 6, 20, RB + 12, RB + 14, 1'b0);
        cfg(31, 8, 9, RB + 15, RB + 16, 1'b1);
        cfg(2, 12, 14, RB + 20, RB + 21, 1'b1);
        cfg(3, 13, 16, RB + 20, RB + 21, 1'b1);
        cfg(4, 6 + seed % 60, 8 + seed % 60 + seed[9:8], RB + 30, RB + 31, 1'b1);
        mode(5'h00, 0);
        slow <= 1'b1;
        run_frame("multi window", 1'b0);
        mode(5'h00, 1);
        mode(5'h01, 1);
        run_frame("rolling", 1'b0);
        mode(5'h01, 31);
        repeat (3) @(negedge clock);
        check("blank", 1, frame_blank_reg);
        run_frame("rolling muted", 1'b1);
        run_frame("rolling new", 1'b0);
        results();
    end
endmodule : mwr_scanner_tb_top
